/* File: src/rcs_consts.svh */
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define RCS_OFF_CTRL      8'h00
`define RCS_OFF_STATUS    8'h04
`define RCS_OFF_CMD       8'h08

// ==========================================================
// control fields
`define RCS_CTRL_WDT_EN   0
`define RCS_CTRL_EXTERNAL_RESET_PIN_EN  1
`define RCS_CTRL_PIN_WK   2
`define RCS_CTRL_CMP_WK   3
`define RCS_CTRL_PROTECT  4
`define RCS_CTRL_RESET    5'h02

// ==========================================================
// status fields
`define RCS_ST_SLEEP      0
`define RCS_ST_PROG       1
`define RCS_ST_PD         3
`define RCS_ST_TO         4
`define RCS_ST_COMPARATOR_WAKE_FLAG       6
`define RCS_ST_PIN_WAKE_FLAG      7

// ==========================================================
// command fields and flag reset {comparator_wake_flag, pin_wake_flag, to, pd}
`define RCS_CMD_SLEEP     0
`define RCS_CMD_CLRWDT    1
`define RCS_CMD_PORTOP    2
`define RCS_FLAGS_POR     4'h3

// ==========================================================
// serial programming
`define RCS_PCMD_LOAD     6'h02
`define RCS_PCMD_READ     6'h04
`define RCS_PCMD_INC      6'h06
`define RCS_PCMD_BITS     6
`define RCS_PDATA_BITS    16
`define RCS_OPEN_WORDS    64

// ==========================================================
// timing
`define RCS_PCLK_NS       25
`define RCS_WDT_PERIOD_NS 18000000

`endif

/* File: src/rcs_pkg.sv */
package rcs_pkg;
  typedef logic [3:0] rcs_flags_t;
  typedef enum logic [1:0] {
    PRG_OFF,
    PRG_CMD,
    PRG_LOAD,
    PRG_READ
  } rcs_prog_state_t;
endpackage : rcs_pkg

/* File: src/rcs_top.sv */
// Notes on behaviour
// [R1] watchdog wake from sleep clears all flags
// [R2] watchdog outside sleep keeps powerdown flag only
// [R3] reset pin wake: timeout 1, rest 0
// [R4] power-up sets timeout, powerdown; sleep clears powerdown
// [R5] reset pin awake clears only wake flags
// [R6] pin-change wake: pin flag, timeout set
// [R7] comparator wake: comparator flag, timeout set
// [R8] flags hold until a reset event or a sleep command
// [R9] reset pin pulse keeps timeout, powerdown flags
// [R10] power-down entered only by sleep command
// [R11] sleep: clear watchdog, set/clear flags, stop oscillator
// [R12] port drive state frozen during sleep; programming mode still drives the pins here
// [R13] watchdog reset never drives reset pin
// [R14] four wake sources, each with enable
// [R15] every wake gives full device reset
// [R16] pin reference taken at last port operation
// [R17] protection hides memory except first 64, last
// [R18] four id words reachable only when programming
// [R19] programmer uses low id bits only
// [R20] programmer enters mode: pins low, high level
// [R21] pin one clocks, pin zero carries data
// [R22] six-bit command then sixteen data bits
`include "rcs_consts.svh"

module rcs_top #(
  parameter int WDT_CYCLES = `RCS_WDT_PERIOD_NS / `RCS_PCLK_NS,
  parameter int MEM_DEPTH  = 512,
  parameter int WORD_W     = 12
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // pins: {port_pin_three, port_pin_one, port_pin_zero}
  input  wire logic [2:0]             port_pin_in,
  input  wire logic                   external_reset_pin_n,
  input  wire logic                   programming_high_level,
  input  wire logic                   comparator_out,
  // core port drive request and held pin drive
  input  wire logic [2:0]             core_port_out,
  input  wire logic [2:0]             core_port_oe,
  output logic [2:0]                  port_pin_out,
  output logic [2:0]                  port_pin_oe,
  // to the core
  output logic                        device_reset,
  output logic                        osc_drive_en,
  output logic                        sleeping,
  output logic                        prog_mode
);
  import rcs_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH + 4);

  initial begin
    if (WDT_CYCLES < 2 || WDT_CYCLES >= (1 << 24)) $error("rcs_top: WDT_CYCLES out of range");
    if (MEM_DEPTH <= `RCS_OPEN_WORDS || WORD_W > `RCS_PDATA_BITS) $error("rcs_top: bad memory shape");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // ==========================================================
  // pin synchronisers: {hv, cmp, rst_n, gp3, gp1, gp0}
  logic [5:0] sync_a_q;
  logic [5:0] sync_b_q;
  logic       rst_n_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_q     <= 6'h08;
      sync_b_q     <= 6'h08;
      rst_n_prev_q <= 1'b1;
    end else begin
      sync_a_q     <= {programming_high_level, comparator_out, external_reset_pin_n, port_pin_in};
      sync_b_q     <= sync_a_q;
      rst_n_prev_q <= sync_b_q[3];
    end
  end

  logic [2:0] pins_s;
  logic       cmp_s;
  logic       hv_s;
  assign pins_s = sync_b_q[2:0];
  assign cmp_s  = sync_b_q[4];
  assign hv_s   = sync_b_q[5];

  // ==========================================================
  // apb
  logic [4:0]  ctrl_q;
  rcs_flags_t  flags_q;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        cmd_wr;
  assign wr_acc = psel && penable && !pready && pwrite;
  assign rd_acc = psel && penable && !pready && !pwrite;
  assign mapped = hit(paddr, `RCS_OFF_CTRL) || hit(paddr, `RCS_OFF_STATUS) || hit(paddr, `RCS_OFF_CMD);
  assign cmd_wr = wr_acc && hit(paddr, `RCS_OFF_CMD);

  logic [31:0] status_word;
  always_comb begin
    status_word                  = 32'h0;
    status_word[`RCS_ST_SLEEP]   = sleeping;
    status_word[`RCS_ST_PROG]    = prog_mode;
    status_word[`RCS_ST_PD]      = flags_q[0];
    status_word[`RCS_ST_TO]      = flags_q[1];
    status_word[`RCS_ST_PIN_WAKE_FLAG]   = flags_q[2];
    status_word[`RCS_ST_COMPARATOR_WAKE_FLAG]    = flags_q[3];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      ctrl_q  <= `RCS_CTRL_RESET;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_acc) begin
        if (hit(paddr, `RCS_OFF_CTRL)) prdata <= {27'h0, ctrl_q};
        else if (hit(paddr, `RCS_OFF_STATUS)) prdata <= status_word;
        else prdata <= 32'h0;
      end
      if (wr_acc && hit(paddr, `RCS_OFF_CTRL)) ctrl_q <= pwdata[4:0];
    end
  end

  // ==========================================================
  // wake and reset events
  logic [23:0] wdt_cnt_q;
  logic [2:0]  pin_ref_q;
  logic        cmp_ref_q;
  logic        wdt_hit;
  logic        ev_ext;
  logic        ev_wdt;
  logic        ev_pin;
  logic        ev_cmp;
  logic        ev_any;
  logic        sleep_go;

  assign wdt_hit  = ctrl_q[`RCS_CTRL_WDT_EN] && wdt_cnt_q == 24'(WDT_CYCLES - 1);
  assign ev_ext   = ctrl_q[`RCS_CTRL_EXTERNAL_RESET_PIN_EN] && rst_n_prev_q && !sync_b_q[3] && !prog_mode; // [R14]
  assign ev_wdt   = wdt_hit && !prog_mode; // [R14]
  assign ev_pin   = sleeping && ctrl_q[`RCS_CTRL_PIN_WK] && pins_s != pin_ref_q; // [R14] [R16]
  assign ev_cmp   = sleeping && ctrl_q[`RCS_CTRL_CMP_WK] && cmp_s != cmp_ref_q; // [R14]
  assign ev_any   = ev_ext || ev_wdt || ev_pin || ev_cmp;
  assign sleep_go = cmd_wr && pwdata[`RCS_CMD_SLEEP] && !sleeping && !prog_mode && !ev_any; // [R10]

  // watchdog keeps running through sleep; cleared at entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_q <= 24'h0;
    end else if (sleep_go || ev_any || !ctrl_q[`RCS_CTRL_WDT_EN]
                 || (cmd_wr && pwdata[`RCS_CMD_CLRWDT])) begin
      wdt_cnt_q <= 24'h0; // [R11]
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 24'h1;
    end
  end

  // references: pins at last port operation, comparator at sleep entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ref_q <= 3'h0;
      cmp_ref_q <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[`RCS_CMD_PORTOP]) pin_ref_q <= pins_s; // [R16]
      if (sleep_go) cmp_ref_q <= cmp_s;
    end
  end

  // flags {comparator_wake_flag, pin_wake_flag, to, pd}; priority ext, wdt, pin, cmp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `RCS_FLAGS_POR; // [R4]
    end else if (ev_ext) begin
      if (sleeping) flags_q <= 4'h2; // [R3]
      else flags_q[3:2] <= 2'h0; // [R5] [R9]
    end else if (ev_wdt) begin
      if (sleeping) flags_q <= 4'h0; // [R1]
      else flags_q[3:1] <= 3'h0; // [R2]
    end else if (ev_pin) begin
      flags_q <= 4'h6; // [R6]
    end else if (ev_cmp) begin
      flags_q <= 4'ha; // [R7]
    end else if (sleep_go) begin
      flags_q[1:0] <= 2'h2; // [R4] [R11]
    end
    // otherwise held [R8]
  end

  // reset goes only to the core; the reset pin has no driver here [R13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping     <= 1'b0;
      device_reset <= 1'b1;
      osc_drive_en <= 1'b1;
    end else begin
      device_reset <= ev_any; // [R15]
      if (ev_any) begin
        sleeping     <= 1'b0;
        osc_drive_en <= 1'b1;
      end else if (sleep_go) begin
        sleeping     <= 1'b1;
        osc_drive_en <= 1'b0; // [R11]
      end
    end
  end

  // ==========================================================
  // programming mode and serial link
  rcs_prog_state_t    pst_q;
  logic [4:0]         bit_cnt_q;
  logic [15:0]        shreg_q;
  logic [AW-1:0]      addr_q;
  logic               sclk_prev_q;
  logic               hv_prev_q;
  logic               sclk_rise;
  logic               prog_enter;
  logic [WORD_W-1:0]  mem [MEM_DEPTH + 4];
  logic [WORD_W-1:0]  rd_word;
  logic               readable;
  logic [15:0]        load_word;

  // word as it stands once the last data bit shifts in
  assign load_word  = {pins_s[0], shreg_q[15:1]};
  assign sclk_rise  = pins_s[1] && !sclk_prev_q; // [R21]
  assign prog_enter = hv_s && !hv_prev_q && pins_s[1:0] == 2'b00; // [R20]
  // ids sit past the last program word, so only this path reaches them [R18]
  assign readable   = !ctrl_q[`RCS_CTRL_PROTECT] || addr_q < AW'(`RCS_OPEN_WORDS)
                      || addr_q >= AW'(MEM_DEPTH - 1); // [R17]
  assign rd_word    = readable ? mem[addr_q] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'b0;
      hv_prev_q   <= 1'b0;
    end else begin
      sclk_prev_q <= pins_s[1];
      hv_prev_q   <= hv_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_q     <= PRG_OFF;
      bit_cnt_q <= 5'h0;
      shreg_q   <= 16'h0;
      addr_q    <= '0;
    end else if (!hv_s) begin
      pst_q <= PRG_OFF;
    end else begin
      case (pst_q)
        PRG_OFF: begin
          if (prog_enter) begin
            pst_q     <= PRG_CMD;
            bit_cnt_q <= 5'h0;
            addr_q    <= '0;
          end
        end
        PRG_CMD: begin
          if (sclk_rise) begin
            shreg_q   <= {pins_s[0], shreg_q[15:1]}; // [R21]
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == 5'(`RCS_PCMD_BITS - 1)) begin // [R22]
              bit_cnt_q <= 5'h0;
              case ({pins_s[0], shreg_q[15:11]})
                `RCS_PCMD_LOAD: pst_q <= PRG_LOAD;
                `RCS_PCMD_READ: begin
                  pst_q   <= PRG_READ;
                  shreg_q <= 16'(rd_word);
                end
                `RCS_PCMD_INC: begin
                  if (addr_q != AW'(MEM_DEPTH + 3)) addr_q <= addr_q + 1'b1;
                end
                default: pst_q <= PRG_CMD;
              endcase
            end
          end
        end
        PRG_LOAD: begin
          if (sclk_rise) begin
            shreg_q   <= {pins_s[0], shreg_q[15:1]};
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == 5'(`RCS_PDATA_BITS - 1)) begin // [R22]
              bit_cnt_q <= 5'h0;
              pst_q     <= PRG_CMD;
            end
          end
        end
        PRG_READ: begin
          if (sclk_rise) begin
            shreg_q   <= {1'b0, shreg_q[15:1]};
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == 5'(`RCS_PDATA_BITS - 1)) begin // [R22]
              bit_cnt_q <= 5'h0;
              pst_q     <= PRG_CMD;
            end
          end
        end
        default: pst_q <= PRG_OFF;
      endcase
    end
  end

  // no reset on the array: it stands for non-volatile storage
  always_ff @(posedge pclk) begin
    if (hv_s && pst_q == PRG_LOAD && sclk_rise && bit_cnt_q == 5'(`RCS_PDATA_BITS - 1)) begin
      mem[addr_q] <= load_word[WORD_W-1:0]; // [R18]
    end
  end

  // ==========================================================
  // pin drive: frozen in sleep, pin zero carries read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_out <= 3'h0;
      port_pin_oe  <= 3'h0;
      prog_mode    <= 1'b0;
    end else begin
      prog_mode <= hv_s && (pst_q != PRG_OFF || prog_enter);
      if (hv_s && pst_q == PRG_READ) begin
        port_pin_out <= {2'h0, shreg_q[0]}; // [R21]
        port_pin_oe  <= 3'h1;
      end else if (hv_s && pst_q != PRG_OFF) begin
        port_pin_out <= 3'h0;
        port_pin_oe  <= 3'h0;
      end else if (!sleeping && !sleep_go) begin
        port_pin_out <= core_port_out;
        port_pin_oe  <= core_port_oe;
      end
      // asleep: both held [R12]
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wdt_sleep_wake: assert property (ev_wdt && sleeping && !ev_ext |=> flags_q == 4'h0) // [R1]
    else $error("wdt wake from sleep left a flag set");
  a_wdt_awake: assert property (ev_wdt && !sleeping && !ev_ext |=> flags_q[3:1] == 3'h0
                                && flags_q[0] == $past(flags_q[0])) // [R2]
    else $error("wdt reset outside sleep flags wrong");
  a_ext_sleep: assert property (ev_ext && sleeping |=> flags_q == 4'h2 && device_reset) // [R3]
    else $error("reset pin wake flags wrong");
  a_sleep_flags: assert property (sleep_go |=> flags_q[1:0] == 2'h2 && sleeping && !osc_drive_en) // [R11]
    else $error("sleep entry state wrong");
  a_ext_awake: assert property (ev_ext && !sleeping |=> flags_q[1:0] == $past(flags_q[1:0])
                                && flags_q[3:2] == 2'h0) // [R5]
    else $error("reset pin outside sleep changed timeout or powerdown");
  a_pin_wake: assert property (ev_pin && !ev_ext && !ev_wdt |=> flags_q == 4'h6 && !sleeping) // [R6]
    else $error("pin wake flags wrong");
  a_cmp_wake: assert property (ev_cmp && !ev_pin && !ev_ext && !ev_wdt |=> flags_q == 4'ha) // [R7]
    else $error("comparator wake flags wrong");
  a_flags_hold: assert property (!ev_any && !sleep_go |=> $stable(flags_q)) // [R8]
    else $error("flags moved without an event");
  a_sleep_only: assert property ($rose(sleeping) |-> $past(cmd_wr && pwdata[`RCS_CMD_SLEEP])) // [R10]
    else $error("sleep entered without command");
  a_port_hold: assert property (sleeping && $past(sleeping) && !prog_mode |-> $stable(port_pin_oe)
                                && $stable(port_pin_out)) // [R12]
    else $error("port drive changed while asleep");
  a_wake_reset: assert property (ev_any |=> device_reset ##1 !sleeping) // [R15]
    else $error("wake did not reset the core");

  c_pin_wake: cover property (sleeping ##[1:1000] ev_pin);
  c_wdt_sleep: cover property (sleeping && ev_wdt);
  c_prog_read: cover property (pst_q == PRG_READ ##[1:300] pst_q == PRG_CMD);
  c_ext_awake: cover property (!sleeping && ev_ext);

endmodule : rcs_top

/* File: dv/rcs_partner.sv */
// ==========================================================
// reset source, wake inputs and serial programmer
module rcs_partner (
  // clock and pins seen from the device
  input  wire logic       pclk,
  input  wire logic [2:0] port_pin_out,
  input  wire logic [2:0] port_pin_oe,
  // pins driven towards the device
  output logic [2:0]      port_pin_in,
  output logic            external_reset_pin_n,
  output logic            programming_high_level,
  output logic            comparator_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] pins;
  logic       pin0_drv;
  // released data line shows the inverse of the last bit, not a stale copy
  assign port_pin_in = (port_pin_oe & port_pin_out)
                     | (~port_pin_oe & {pins[2:1], pin0_drv ? pins[0] : ~pins[0]});
  initial begin
    pins = 3'h4;
    pin0_drv = 1'b1;
    external_reset_pin_n = 1'b1;
    programming_high_level = 1'b0;
    comparator_out = 1'b0;
  end
  task automatic reset_pulse();
    @(posedge pclk);
    external_reset_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    external_reset_pin_n <= 1'b1;
  endtask : reset_pulse
  task automatic set_pins(input logic [2:0] v);
    @(posedge pclk);
    pins <= v;
  endtask : set_pins
  task automatic cmp_toggle();
    @(posedge pclk);
    comparator_out <= ~comparator_out;
  endtask : cmp_toggle
  task automatic prog_enter();
    @(posedge pclk);
    pins <= 3'h4;
    repeat (4) @(posedge pclk);
    programming_high_level <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : prog_enter
  // data set while the clock is low, read just before the rise
  task automatic clk_bit(input logic b, output logic r);
    @(posedge pclk);
    pins[0] <= b;
    pins[1] <= 1'b0;
    repeat (4) @(posedge pclk);
    r = port_pin_in[0];
    pins[1] <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : clk_bit
  task automatic send(input logic [15:0] v, input int n);
    logic r;
    for (int i = 0; i < n; i++) clk_bit(v[i], r);
  endtask : send
  task automatic recv(output logic [15:0] v);
    @(posedge pclk);
    pin0_drv <= 1'b0;
    for (int i = 0; i < 16; i++) clk_bit(pins[0], v[i]);
    pin0_drv <= 1'b1;
  endtask : recv
endmodule : rcs_partner

/* File: dv/tb_top.sv */
`include "rcs_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] WD = 32'h1 << `RCS_CTRL_WDT_EN;
  localparam logic [31:0] MC = 32'h1 << `RCS_CTRL_EXTERNAL_RESET_PIN_EN;
  localparam logic [31:0] PW = 32'h1 << `RCS_CTRL_PIN_WK;
  localparam logic [31:0] CW = 32'h1 << `RCS_CTRL_CMP_WK;
  localparam logic [31:0] PR = 32'h1 << `RCS_CTRL_PROTECT;
  localparam logic [31:0] SL = 32'h1 << `RCS_CMD_SLEEP;
  localparam logic [31:0] CL = 32'h1 << `RCS_CMD_CLRWDT;
  localparam logic [31:0] PO = 32'h1 << `RCS_CMD_PORTOP;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic external_reset_pin_n, programming_high_level, comparator_out;
  logic device_reset, osc_drive_en, sleeping, prog_mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] port_pin_in, core_port_out, core_port_oe, port_pin_out, port_pin_oe;
  logic [32:0] exp_q[$];
  logic [15:0] w, r;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  rcs_top #(.WDT_CYCLES(50)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .port_pin_in, .external_reset_pin_n, .programming_high_level, .comparator_out,
    .core_port_out, .core_port_oe, .port_pin_out, .port_pin_oe, .device_reset, .osc_drive_en,
    .sleeping, .prog_mode);
  rcs_partner prt (.pclk, .port_pin_out, .port_pin_oe, .port_pin_in, .external_reset_pin_n,
    .programming_high_level, .comparator_out);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // read data is taken at the edge where pready is sampled high
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  // ==========================================================
  // bus and event helpers
  function automatic logic [31:0] st(input logic [3:0] f, input logic s);
    st = 32'h0;
    st[`RCS_ST_COMPARATOR_WAKE_FLAG] = f[3];
    st[`RCS_ST_PIN_WAKE_FLAG] = f[2];
    st[`RCS_ST_TO] = f[1];
    st[`RCS_ST_PD] = f[0];
    st[`RCS_ST_SLEEP] = s;
  endfunction : st
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_rst();
    int n;
    n = 0;
    while (device_reset !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check(device_reset, 1);
    repeat (4) @(posedge pclk);
  endtask : wait_rst
  // 0 reset pin, 1 pin change, 2 comparator, 3 watchdog
  task automatic wake(input int k);
    fork
      case (k)
        0: prt.reset_pulse();
        1: prt.set_pins(3'h5);
        2: prt.cmp_toggle();
        default: ;
      endcase
      wait_rst();
    join
  endtask : wake

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    core_port_out = 3'h0;
    core_port_oe = 3'h0;
    void'($urandom(67));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RCS_OFF_STATUS, st(4'h3, 0));
    rd(`RCS_OFF_CTRL, `RCS_CTRL_RESET);
    rd(8'h0c, 32'h0, 1'b1);
    apb(1'b1, `RCS_OFF_CMD, CL);
    rd(`RCS_OFF_STATUS, st(4'h3, 0));
    $display("test power-up done");
    apb(1'b1, `RCS_OFF_CTRL, WD | MC);
    wake(3);
    apb(1'b1, `RCS_OFF_CTRL, MC);
    rd(`RCS_OFF_STATUS, st(4'h1, 0));
    apb(1'b1, `RCS_OFF_CTRL, WD | MC);
    apb(1'b1, `RCS_OFF_CMD, SL);
    wake(3);
    apb(1'b1, `RCS_OFF_CTRL, MC);
    rd(`RCS_OFF_STATUS, st(4'h0, 0));
    $display("test watchdog done");
    core_port_out <= 3'h5;
    core_port_oe <= 3'h7;
    apb(1'b1, `RCS_OFF_CMD, SL);
    rd(`RCS_OFF_STATUS, st(4'h2, 1));
    check(osc_drive_en, 0);
    core_port_out <= 3'h2;
    repeat (4) @(posedge pclk);
    check({port_pin_oe, port_pin_out}, 6'h3d);
    wake(0);
    rd(`RCS_OFF_STATUS, st(4'h2, 0));
    core_port_oe <= 3'h0;
    $display("test sleep done");
    apb(1'b1, `RCS_OFF_CTRL, MC | PW);
    apb(1'b1, `RCS_OFF_CMD, PO);
    apb(1'b1, `RCS_OFF_CMD, SL);
    wake(1);
    rd(`RCS_OFF_STATUS, st(4'h6, 0));
    prt.set_pins(3'h4);
    wake(0);
    rd(`RCS_OFF_STATUS, st(4'h2, 0));
    apb(1'b1, `RCS_OFF_CTRL, MC | CW);
    apb(1'b1, `RCS_OFF_CMD, SL);
    wake(2);
    rd(`RCS_OFF_STATUS, st(4'ha, 0));
    $display("test wake sources done");
    apb(1'b1, `RCS_OFF_CTRL, MC);
    prt.prog_enter();
    check(prog_mode, 1);
    w = 16'($urandom);
    prt.send(`RCS_PCMD_LOAD, 6);
    prt.send(w, 16);
    prt.send(`RCS_PCMD_READ, 6);
    prt.recv(r);
    check(r, {4'h0, w[11:0]});
    apb(1'b1, `RCS_OFF_CTRL, MC | PR);
    repeat (`RCS_OPEN_WORDS) prt.send(`RCS_PCMD_INC, 6);
    prt.send(`RCS_PCMD_LOAD, 6);
    prt.send(16'($urandom), 16);
    prt.send(`RCS_PCMD_READ, 6);
    prt.recv(r);
    check(r, 0);
    repeat (512 - `RCS_OPEN_WORDS) prt.send(`RCS_PCMD_INC, 6);
    w = 16'($urandom) & 16'h000f;
    prt.send(`RCS_PCMD_LOAD, 6);
    prt.send(w, 16);
    prt.send(`RCS_PCMD_READ, 6);
    prt.recv(r);
    check(r, w);
    $display("test programming done");
    complete_run();
  end
endmodule : tb_top
